// ===== core/step_pkg.sv
// Purpose: shared constants and types for the step advance controller
// Assumes: 32-bit AHB-Lite register bus, one clock
// Notes: all offsets and fields live here; reset values sit in the modules
package step_pkg;

	// ==========================================================
	// register map
	localparam logic [7:0] CTRL_OFFSET = 8'h00; // mode and command pulses
	localparam logic [7:0] STATUS_OFFSET = 8'h04; // holds and gate state

	// ==========================================================
	// control register fields
	localparam int MODE_LSB = 0; // mode field, three bits
	localparam int START_BIT = 8; // write one: start pulse
	localparam int STOP_BIT = 9; // write one: stop pulse
	localparam int STEP_BIT = 10; // write one: step press
	localparam int CLEAR_BIT = 11; // write one: start-group selection

	// ==========================================================
	// status register fields
	localparam int ST_STOP_BIT = 0;
	localparam int ST_INT_BIT = 1;
	localparam int ST_REP_BIT = 2;
	localparam int ST_EXT_BIT = 3;
	localparam int ST_FIRST_BIT = 4;
	localparam int ST_SECOND_BIT = 5;
	localparam int ST_DEV_LSB = 8; // device holds, one bit each

	// ==========================================================
	// devices with lockout: four tape units, then others
	localparam int DEV_COUNT = 8;
	localparam int DEV_SEL_W = 3;

	// ==========================================================
	// bus constants
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	localparam logic [1:0] HTRANS_SEQ = 2'h3;
	localparam logic [31:0] READ_ZERO = 32'h0;

	// test modes, mutually exclusive
	typedef enum logic [2:0] {
		MODE_NORMAL,
		MODE_CLOCK_MANUAL,
		MODE_CLOCK_AUTO,
		MODE_DIST_MANUAL,
		MODE_OP_MANUAL,
		MODE_OP_AUTO
	} mode_t;

	// requests from the command timing unit
	typedef struct packed {
		logic waitInternal; // internal reference begun
		logic waitRepeat; // repeat sequence begun
		logic waitTapeRw; // tape read or write begun
		logic testLockout; // lockout test on first step pulse
		logic [DEV_SEL_W-1:0] devSel; // device addressed
		logic [DEV_COUNT-1:0] initLockout; // device operation begun
	} timing_req_t;

	// completion signals
	typedef struct packed {
		logic arithDone; // arithmetic_sequencer resume
		logic repeatDone; // repeat_sequencer resume
		logic accessDone; // arith_register_access resume
		logic coreDone; // core_store resume
		logic drumDone; // drum_store resume
		logic [DEV_COUNT-1:0] devDone; // device resumes
	} resume_t;

endpackage

// ===== core/burst_gate.sv
// Purpose: two-flip-flop burst gate emitting controlled clock pulses
// Assumes: basic clock pulses arrive as one-cycle strobes on mclk
// Notes: both flip-flops rest at one; terminate forces both to one
`timescale 1ns/1ps

module burst_gate (
	input wire logic mclk,
	input wire logic rstN,
	input wire logic basicPulse,
	input wire logic trigger,
	input wire logic terminate,
	output logic ctlPulse,
	output logic firstRun,
	output logic secondRun
);

	// ==========================================================
	// state
	typedef struct packed {
		logic first; // burst_run_ff first stage
		logic second; // burst_run_ff second stage
	} gate_t;

	gate_t gate_reg; // registered gate
	gate_t gate_next; // next gate

	// pulse passes only while both stages are zero
	assign ctlPulse = basicPulse & ~gate_reg.first & ~gate_reg.second;
	assign firstRun = gate_reg.first;
	assign secondRun = gate_reg.second;

	// next-state logic
	always_comb begin
		gate_next = gate_reg;
		if (trigger) begin
			gate_next.first = 1'b0;
		end
		if (basicPulse && !gate_reg.first) begin
			gate_next.second = 1'b0;
		end
		// termination wins over a trigger
		if (terminate) begin
			gate_next.first = 1'b1;
			gate_next.second = 1'b1;
		end
	end

	// state register
	always_ff @(posedge mclk or negedge rstN) begin
		if (!rstN) begin
			gate_reg <= '{first: 1'b1, second: 1'b1};
		end else begin
			gate_reg <= gate_next;
		end
	end

	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rstN);

	sequence s_trig;
		trigger && !terminate;
	endsequence

	property p_trig_open;
		s_trig |=> !firstRun;
	endproperty
	a_trig_open: assert property (p_trig_open) else $error("trigger did not open");

	property p_second_open;
		!firstRun && basicPulse && !terminate |=> !secondRun ##0 !firstRun;
	endproperty
	a_second_open: assert property (p_second_open) else $error("second stage stuck");

endmodule

// ===== core/step_advance_control.sv
// Purpose: step_advance_controller gating controlled pulses into advances
// Assumes: 125 MHz mclk, AHB-Lite slave, strobes synchronous to mclk
// Notes: zero-wait-state bus; read data registered in address phase
// Notes on behaviour
// - distributor step gives one advance, burst ends
// - distributor burst ends only on three pulses
// - incomplete reference: next step runs continuous burst
// - arithmetic or repeat resume ends burst, re-enables single step
// - step operation burst runs to the end of the current instruction
// - auto step operation: oscillator starts, step ignored
// - advance steps sequencer; withheld while holds pending
// - start clears stop, advances then pass
// - start-group selection clears internal, repeat, external holds
// - stop sets stop flip-flop, blocks advances
// - wait-internal request sets internal hold
// - internal hold blocks advance and tape clock
// - internal completion resumes clear internal hold
// - wait-repeat request sets repeat hold
// - repeat resume clears repeat hold
// - tape read/write always halts; others when busy
// - separate hold per tape unit
// - lockout test leaves idle unit unchanged
// - trigger opens first stage, next pulse second
// - device resume then next pulse clears external hold
//
// Register access over AHB-Lite and the address map were chosen for this implementation.
`timescale 1ns/1ps

module step_advance_control #(
	parameter int DEVICES = step_pkg::DEV_COUNT
) (
	input wire logic mclk,
	input wire logic rst_n,
	// AHB-Lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	// pulse sources
	input wire logic basicPulse,
	input wire logic lowSpeedPulse,
	input wire logic stopSignal,
	input wire logic finalStepPulse,
	// command timing unit and resumes
	input wire step_pkg::timing_req_t timingReq,
	input wire step_pkg::resume_t resume,
	// outputs to sequencer and controls
	output logic stepAdvancePulse,
	output logic ctlPulse,
	output logic tapeSeqClock,
	output logic [DEVICES-1:0] devRefEnable
);

	// ==========================================================
	// reset release
	logic rstMeta; // first release stage
	logic rstN; // released reset used everywhere

	// two-stage release of the asynchronous reset
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			rstMeta <= 1'b0;
			rstN <= 1'b0;
		end else begin
			rstMeta <= 1'b1;
			rstN <= rstMeta;
		end
	end

	// ==========================================================
	// state
	typedef struct packed {
		step_pkg::mode_t mode; // selected test mode
		logic stopFf; // stop flip-flop
		logic waitInt; // internal hold
		logic waitRep; // repeat hold
		logic extHold; // external hold
		logic [step_pkg::DEV_SEL_W-1:0] extDev; // device that caused ext hold
		logic [DEVICES-1:0] devHold; // per-device hold, tape units first
		logic wrPend; // write data phase pending
		logic [7:0] wrAddr; // write address
		logic startCmd; // one-cycle command pulses
		logic stopCmd;
		logic stepCmd;
		logic clearCmd;
		logic [31:0] rdData; // registered read data
	} state_t;

	state_t st_reg; // registered state
	state_t st_next; // next state

	logic firstRun; // burst first stage
	logic secondRun; // burst second stage
	logic trigger; // burst start
	logic terminate; // burst end
	logic advanceOpen; // advance path enabled
	logic addrPhase; // valid address phase
	logic [31:0] statusWord; // status read value
	logic intDone; // any internal completion

	// ==========================================================
	// helpers

	// register word decode
	function automatic logic isReg(input logic [31:0] a, input logic [7:0] off);
		return (a[7:2] == off[7:2]) && (a[31:8] == 24'h000000);
	endfunction

	// ==========================================================
	// burst gate
	burst_gate u_gate (
		.mclk(mclk),
		.rstN(rstN),
		.basicPulse(basicPulse),
		.trigger(trigger),
		.terminate(terminate),
		.ctlPulse(ctlPulse),
		.firstRun(firstRun),
		.secondRun(secondRun)
	);

	// ==========================================================
	// advance path
	assign intDone = resume.arithDone | resume.accessDone | resume.coreDone | resume.drumDone;
	assign advanceOpen = ~st_reg.stopFf & ~st_reg.waitInt & ~st_reg.waitRep & ~st_reg.extHold;
	assign stepAdvancePulse = ctlPulse & advanceOpen;
	// tape clock blocked by internal hold
	assign tapeSeqClock = ctlPulse & ~st_reg.waitInt;
	// reference enable for each idle device
	assign devRefEnable = ~st_reg.devHold;

	// trigger and termination selection per mode
	always_comb begin
		trigger = 1'b0;
		terminate = 1'b0;
		case (st_reg.mode)
			step_pkg::MODE_NORMAL: begin
				trigger = st_reg.startCmd;
				terminate = st_reg.stopCmd | stopSignal;
			end
			step_pkg::MODE_CLOCK_MANUAL: begin
				trigger = st_reg.stepCmd;
				terminate = ctlPulse;
			end
			step_pkg::MODE_CLOCK_AUTO: begin
				trigger = lowSpeedPulse & ~st_reg.stopFf;
				terminate = ctlPulse;
			end
			step_pkg::MODE_DIST_MANUAL: begin
				trigger = st_reg.stepCmd;
				terminate = stepAdvancePulse | resume.arithDone | resume.repeatDone;
			end
			step_pkg::MODE_OP_MANUAL: begin
				trigger = st_reg.stepCmd;
				terminate = finalStepPulse;
			end
			step_pkg::MODE_OP_AUTO: begin
				trigger = lowSpeedPulse & ~st_reg.stopFf;
				terminate = finalStepPulse;
			end
			default: begin
				trigger = 1'b0;
				terminate = 1'b1;
			end
		endcase
	end

	// ==========================================================
	// bus
	assign addrPhase = hsel & hready & (htrans == step_pkg::HTRANS_NONSEQ
		| htrans == step_pkg::HTRANS_SEQ);
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign hrdata = st_reg.rdData;

	// status word assembly
	always_comb begin
		statusWord = step_pkg::READ_ZERO;
		statusWord[step_pkg::ST_STOP_BIT] = st_reg.stopFf;
		statusWord[step_pkg::ST_INT_BIT] = st_reg.waitInt;
		statusWord[step_pkg::ST_REP_BIT] = st_reg.waitRep;
		statusWord[step_pkg::ST_EXT_BIT] = st_reg.extHold;
		statusWord[step_pkg::ST_FIRST_BIT] = firstRun;
		statusWord[step_pkg::ST_SECOND_BIT] = secondRun;
		statusWord[step_pkg::ST_DEV_LSB +: DEVICES] = st_reg.devHold;
	end

	// ==========================================================
	// next state
	always_comb begin
		st_next = st_reg;
		st_next.startCmd = 1'b0;
		st_next.stopCmd = 1'b0;
		st_next.stepCmd = 1'b0;
		st_next.clearCmd = 1'b0;
		st_next.wrPend = 1'b0;

		// address phase: latch write, fetch read data
		if (addrPhase) begin
			st_next.wrPend = hwrite;
			st_next.wrAddr = haddr[7:0];
			if (!hwrite) begin
				if (isReg(haddr, step_pkg::CTRL_OFFSET)) begin
					st_next.rdData = {29'h0, st_reg.mode};
				end else if (isReg(haddr, step_pkg::STATUS_OFFSET)) begin
					st_next.rdData = statusWord;
				end else begin
					st_next.rdData = step_pkg::READ_ZERO;
				end
			end
		end

		// data phase of a control write
		if (st_reg.wrPend && isReg({24'h000000, st_reg.wrAddr}, step_pkg::CTRL_OFFSET)) begin
			st_next.mode = step_pkg::mode_t'(hwdata[step_pkg::MODE_LSB +: 3]);
			st_next.startCmd = hwdata[step_pkg::START_BIT];
			st_next.stopCmd = hwdata[step_pkg::STOP_BIT];
			st_next.stepCmd = hwdata[step_pkg::STEP_BIT];
			st_next.clearCmd = hwdata[step_pkg::CLEAR_BIT];
		end

		if (st_reg.startCmd) begin
			st_next.stopFf = 1'b0;
		end
		if (st_reg.stopCmd || stopSignal) begin
			st_next.stopFf = 1'b1;
		end

		if (st_reg.clearCmd) begin
			st_next.waitInt = 1'b0;
			st_next.waitRep = 1'b0;
			st_next.extHold = 1'b0;
		end

		if (intDone) begin
			st_next.waitInt = 1'b0;
		end
		if (timingReq.waitInternal) begin
			st_next.waitInt = 1'b1;
		end

		if (resume.repeatDone) begin
			st_next.waitRep = 1'b0;
		end
		if (timingReq.waitRepeat) begin
			st_next.waitRep = 1'b1;
		end

		st_next.devHold = (st_reg.devHold & ~resume.devDone) | timingReq.initLockout;

		// idle device and pulse clear ext hold
		if (st_reg.extHold && ctlPulse && !st_reg.devHold[st_reg.extDev]) begin
			st_next.extHold = 1'b0;
		end
		// lockout test sets only on busy device
		if (timingReq.testLockout && st_reg.devHold[timingReq.devSel]) begin
			st_next.extHold = 1'b1;
			st_next.extDev = timingReq.devSel;
		end
		// tape read or write always halts
		if (timingReq.waitTapeRw) begin
			st_next.extHold = 1'b1;
			st_next.extDev = timingReq.devSel;
		end
	end

	// state register
	always_ff @(posedge mclk or negedge rstN) begin
		if (!rstN) begin
			st_reg <= '{mode: step_pkg::MODE_NORMAL, stopFf: 1'b1, waitInt: 1'b0,
				waitRep: 1'b0, extHold: 1'b0, extDev: '0, devHold: '0, wrPend: 1'b0,
				wrAddr: 8'h00, startCmd: 1'b0, stopCmd: 1'b0, stepCmd: 1'b0,
				clearCmd: 1'b0, rdData: 32'h0};
		end else begin
			st_reg <= st_next;
		end
	end

	// ==========================================================
	// checks
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rstN);

	sequence s_dist_step;
		st_reg.mode == step_pkg::MODE_DIST_MANUAL && stepAdvancePulse;
	endsequence

	property p_dist_single;
		s_dist_step |=> firstRun && secondRun;
	endproperty
	a_dist_single: assert property (p_dist_single) else $error("burst outlived advance");

	property p_int_set;
		timingReq.waitInternal |=> st_reg.waitInt ##0 !stepAdvancePulse;
	endproperty
	a_int_set: assert property (p_int_set) else $error("internal hold not set");

	property p_int_clear;
		intDone && !timingReq.waitInternal |=> !st_reg.waitInt;
	endproperty
	a_int_clear: assert property (p_int_clear) else $error("internal hold kept");

	property p_tape_clock;
		st_reg.waitInt |-> !tapeSeqClock && !stepAdvancePulse;
	endproperty
	a_tape_clock: assert property (p_tape_clock) else $error("clock passed hold");

	property p_rep;
		timingReq.waitRepeat |=> st_reg.waitRep ##1 (st_reg.waitRep || $past(resume.repeatDone));
	endproperty
	a_rep: assert property (p_rep) else $error("repeat hold wrong");

	property p_rep_clear;
		resume.repeatDone && !timingReq.waitRepeat |=> !st_reg.waitRep;
	endproperty
	a_rep_clear: assert property (p_rep_clear) else $error("repeat hold kept");

	property p_stop;
		st_reg.stopCmd || stopSignal |=> st_reg.stopFf && !stepAdvancePulse;
	endproperty
	a_stop: assert property (p_stop) else $error("stop not taken");

	property p_start;
		st_reg.startCmd && !st_reg.stopCmd && !stopSignal |=> !st_reg.stopFf;
	endproperty
	a_start: assert property (p_start) else $error("start not taken");

	property p_tape_rw;
		timingReq.waitTapeRw |=> st_reg.extHold;
	endproperty
	a_tape_rw: assert property (p_tape_rw) else $error("tape access not held");

	property p_op_ignore;
		st_reg.mode == step_pkg::MODE_OP_AUTO && firstRun && !lowSpeedPulse |=> firstRun;
	endproperty
	a_op_ignore: assert property (p_op_ignore) else $error("step not ignored");

endmodule

// ===== test/step_seq_model.sv
// Purpose: far-side model, step sequencer and reference completion controls
// Assumes: wait requests ride on the advance that starts the reference
// Notes: a resume comes after doneDelay controlled pulses, doneDelay >= 1
`timescale 1ns/1ps

module step_seq_model (
	input wire logic mclk,
	input wire logic rstN,
	input wire logic stepAdvancePulse,
	input wire logic ctlPulse,
	input wire logic arm,
	input wire logic [1:0] armKind,
	input wire logic [1:0] doneSel,
	input wire logic [3:0] doneDelay,
	output step_pkg::timing_req_t req,
	output step_pkg::resume_t res,
	output logic finalStepPulse
);
	// ==========================================================
	// state
	logic [2:0] stepIdx; // step the sequencer stands on
	logic [1:0] armed; // 1 internal, 2 repeat, raised on next advance
	logic [1:0] pending; // reference now running
	logic [1:0] doneKind; // reference that just completed
	logic [3:0] ctlSeen; // controlled pulses spent on it
	logic fire; // one-cycle resume strobe

	assign finalStepPulse = stepAdvancePulse && stepIdx == 3'h7;

	// ==========================================================
	// requests and resumes
	always_comb begin
		req = '0;
		res = '0;
		req.waitInternal = stepAdvancePulse && armed == 2'h1;
		req.waitRepeat = stepAdvancePulse && armed == 2'h2;
		// internal completion from the chosen source
		res.arithDone = fire && doneKind == 2'h1 && doneSel == 2'h0;
		res.accessDone = fire && doneKind == 2'h1 && doneSel == 2'h1;
		res.coreDone = fire && doneKind == 2'h1 && doneSel == 2'h2;
		res.drumDone = fire && doneKind == 2'h1 && doneSel == 2'h3;
		res.repeatDone = fire && doneKind == 2'h2;
	end

	// ==========================================================
	// step count and reference timing, references need controlled pulses
	always_ff @(posedge mclk or negedge rstN) begin
		if (!rstN) begin
			stepIdx <= 3'h0;
			armed <= 2'h0;
			pending <= 2'h0;
			doneKind <= 2'h0;
			ctlSeen <= 4'h0;
			fire <= 1'b0;
		end else begin
			fire <= 1'b0;
			if (stepAdvancePulse) begin
				stepIdx <= stepIdx + 3'h1;
			end
			if (arm) begin
				armed <= armKind;
			end
			if (stepAdvancePulse && armed != 2'h0) begin
				pending <= armed;
				armed <= 2'h0;
				ctlSeen <= 4'h0;
			end else if (pending != 2'h0 && ctlPulse) begin
				if (ctlSeen + 4'h1 == doneDelay) begin
					fire <= 1'b1;
					doneKind <= pending;
					pending <= 2'h0;
				end else begin
					ctlSeen <= ctlSeen + 4'h1;
				end
			end
		end
	end
endmodule

// ===== test/step_advance_control_tb.sv
// Purpose: self-checking bench for step_advance_control
// Assumes: zero-wait bus slave, far-side model answers references
// Notes: pulse counts of each burst are compared, seed 30
`timescale 1ns/1ps

module step_advance_control_tb;
	// ==========================================================
	// stimulus and observed signals
	logic mclk = 1'b0;
	logic rst_n = 1'b0;
	logic hsel = 1'b0;
	logic hwrite = 1'b0;
	logic [1:0] htrans = 2'h0;
	logic [2:0] hsize = 3'h2;
	logic [31:0] haddr = 32'h0;
	logic [31:0] hwdata = 32'h0;
	logic basicPulse = 1'b0;
	logic lowSpeedPulse = 1'b0;
	logic stopSignal = 1'b0;
	logic arm = 1'b0;
	logic [1:0] armKind = 2'h0;
	logic [1:0] doneSel = 2'h0;
	logic [3:0] doneDelay = 4'h1;
	step_pkg::timing_req_t tbReq = '0;
	step_pkg::resume_t tbRes = '0;
	step_pkg::timing_req_t seqReq, q;
	step_pkg::resume_t seqRes, s;
	logic hreadyout, hresp, stepAdvancePulse, ctlPulse, tapeSeqClock, finalStepPulse;
	logic [31:0] hrdata, rd; // rd: data of the last read
	logic [7:0] devRefEnable, mask; // mask: expected enables
	logic [3:0] d; // random reference length or burst size
	int n_errors = 0;
	int tests_run = 0;
	int advTotal = 0; // advances since reset
	int nCtl, nAdv, nTape;

	// ==========================================================
	// design and far-side model
	step_advance_control step_advance_control_i (
		.mclk(mclk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .basicPulse(basicPulse),
		.lowSpeedPulse(lowSpeedPulse), .stopSignal(stopSignal),
		.finalStepPulse(finalStepPulse),
		.timingReq(step_pkg::timing_req_t'(tbReq | seqReq)),
		.resume(step_pkg::resume_t'(tbRes | seqRes)),
		.stepAdvancePulse(stepAdvancePulse), .ctlPulse(ctlPulse),
		.tapeSeqClock(tapeSeqClock), .devRefEnable(devRefEnable)
	);
	step_seq_model step_seq_model_i (
		.mclk(mclk), .rstN(rst_n), .stepAdvancePulse(stepAdvancePulse),
		.ctlPulse(ctlPulse), .arm(arm), .armKind(armKind), .doneSel(doneSel),
		.doneDelay(doneDelay), .req(seqReq), .res(seqRes), .finalStepPulse(finalStepPulse)
	);

	// clock, 8 ns period
	initial begin
		forever #4 mclk = ~mclk;
	end

	// ==========================================================
	// helpers
	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		tests_run++;
		if (got !== exp) begin
			$display("wrong value %s expected %0h seen %0h", what, exp, got);
			n_errors++;
		end
	endtask

	// one single word transfer, waits on hready in both phases
	task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] dat);
		@(posedge mclk);
		hsel <= 1'b1;
		haddr <= a;
		hwrite <= wr;
		htrans <= step_pkg::HTRANS_NONSEQ;
		do @(posedge mclk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= dat;
		do @(posedge mclk); while (hreadyout !== 1'b1);
		rd = hrdata;
		check("hresp", 32'h0, {31'h0, hresp});
	endtask

	task automatic cmd(input logic [31:0] dat);
		bus(1'b1, {24'h0, step_pkg::CTRL_OFFSET}, dat);
	endtask

	// n basic pulses back to back, counting what comes out
	task automatic pulses(input int n);
		nCtl = 0;
		nAdv = 0;
		nTape = 0;
		repeat (n) begin
			@(posedge mclk);
			basicPulse <= 1'b1;
			#2;
			nCtl += int'(ctlPulse === 1'b1);
			nAdv += int'(stepAdvancePulse === 1'b1);
			nTape += int'(tapeSeqClock === 1'b1);
		end
		@(posedge mclk);
		basicPulse <= 1'b0;
		advTotal += nAdv;
	endtask

	// one-cycle strobes: requests, resumes, ls[1] stop, ls[0] oscillator
	task automatic strobe(input step_pkg::timing_req_t r, input step_pkg::resume_t c,
			input logic [1:0] ls);
		@(posedge mclk);
		tbReq <= r;
		tbRes <= c;
		stopSignal <= ls[1];
		lowSpeedPulse <= ls[0];
		@(posedge mclk);
		tbReq <= '0;
		tbRes <= '0;
		stopSignal <= 1'b0;
		lowSpeedPulse <= 1'b0;
		#1;
	endtask

	task automatic armRef(input logic [1:0] k, input logic [1:0] sel, input logic [3:0] len);
		@(posedge mclk);
		arm <= 1'b1;
		armKind <= k;
		doneSel <= sel;
		doneDelay <= len;
		@(posedge mclk);
		arm <= 1'b0;
	endtask

	// start in mode m, trigger by step (1) or oscillator (2); expCtl < 0: rest of instruction
	task automatic trial(input logic [2:0] m, input logic [1:0] trig, input int expCtl);
		int e;
		e = (expCtl < 0) ? 8 - (advTotal % 8) : expCtl;
		cmd(32'h100 | 32'(m));
		bus(1'b0, {24'h0, step_pkg::CTRL_OFFSET}, 32'h0);
		check("mode", 32'(m), rd);
		if (trig == 2'h1) begin
			cmd(32'h400 | 32'(m));
		end else begin
			strobe('0, '0, 2'h1);
		end
		pulses(20);
		check("ctl", e, nCtl);
		check("adv", e, nAdv);
	endtask

	task automatic conclude();
		$display("comparisons %0d mismatches %0d", tests_run, n_errors);
		if (n_errors == 0 && tests_run > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	// watchdog against a hang
	initial begin
		repeat (20000) @(posedge mclk);
		n_errors++;
		conclude();
	end

	// ==========================================================
	// main sequence
	initial begin
		void'($urandom(30));
		repeat (3) @(posedge mclk);
		rst_n <= 1'b1;
		repeat (3) @(posedge mclk);
		bus(1'b0, {24'h0, step_pkg::STATUS_OFFSET}, 32'h0);
		check("status", 32'h31, rd);
		bus(1'b1, 32'h8, 32'hffffffff);
		bus(1'b0, 32'h8, 32'h0);
		check("unmapped", 32'h0, rd);
		check("enables", 32'hff, {24'h0, devRefEnable});
		cmd(32'h900);
		pulses(1);
		check("first ctl", 32'h0, nCtl);
		bus(1'b0, {24'h0, step_pkg::STATUS_OFFSET}, 32'h0);
		check("status run", 32'h0, rd);
		d = 4'(3 + $urandom % 8);
		pulses(d);
		check("adv", d, nAdv);
		for (int k = 0; k < 4; k++) begin
			d = 4'(1 + $urandom % 6);
			armRef(2'h1, 2'(k), d);
			pulses(d + 6);
			check("adv int", 5, nAdv);
			check("tape int", 5, nTape);
		end
		d = 4'(1 + $urandom % 6);
		armRef(2'h2, 2'h0, d);
		pulses(d + 6);
		check("adv rep", 5, nAdv);
		check("tape rep", d + 6, nTape);
		for (int u = 0; u < 8; u++) begin
			q = '0;
			q.initLockout = 8'h1 << u;
			strobe(q, '0, 2'h0);
			mask = ~(8'h1 << u);
			check("enables", mask, devRefEnable);
			q = '0;
			q.testLockout = 1'b1;
			q.devSel = 3'(u ^ 1);
			strobe(q, '0, 2'h0);
			pulses(3);
			check("adv idle", 3, nAdv);
			q.devSel = 3'(u);
			strobe(q, '0, 2'h0);
			pulses(3);
			check("adv locked", 0, nAdv);
			s = '0;
			s.devDone = 8'h1 << u;
			strobe('0, s, 2'h0);
			pulses(3);
			check("adv resumed", 2, nAdv);
			if (u < 4) begin
				q = '0;
				q.waitTapeRw = 1'b1;
				q.devSel = 3'(u);
				q.initLockout = 8'h1 << u;
				strobe(q, '0, 2'h0);
				pulses(3);
				check("adv tape", 0, nAdv);
				strobe('0, s, 2'h0);
				pulses(3);
				check("adv tape done", 2, nAdv);
			end
		end
		armRef(2'h1, 2'h2, 4'hf);
		pulses(2);
		q = '0;
		q.waitTapeRw = 1'b1;
		q.initLockout = 8'h1;
		strobe(q, '0, 2'h0);
		cmd(32'h800);
		bus(1'b0, {24'h0, step_pkg::STATUS_OFFSET}, 32'h0);
		check("status cleared", 32'h100, rd);
		pulses(3);
		check("adv cleared", 3, nAdv);
		s = '0;
		s.devDone = 8'h1;
		strobe('0, s, 2'h0);
		strobe('0, '0, 2'h2);
		pulses(4);
		check("ctl stopped", 0, nCtl);
		bus(1'b0, {24'h0, step_pkg::STATUS_OFFSET}, 32'h0);
		check("status stopped", 32'h31, rd);
		trial(3'h1, 2'h1, 1);
		trial(3'h2, 2'h2, 1);
		trial(3'h3, 2'h1, 1);
		trial(3'h4, 2'h1, -1);
		trial(3'h4, 2'h1, 8);
		trial(3'h5, 2'h1, 0);
		trial(3'h5, 2'h2, 8);
		trial(3'h6, 2'h1, 0);
		cmd(32'h103);
		for (int k = 0; k < 2; k++) begin
			d = 4'(1 + $urandom % 6);
			armRef(2'h1, 2'(k * 2), d);
			cmd(32'h403);
			pulses(6);
			check("ctl single", 1, nCtl);
			cmd(32'h403);
			pulses(d + 8);
			check("ctl burst", d + 1 + k, nCtl);
			check("adv burst", k, nAdv);
			cmd(32'h403);
			pulses(6);
			check("adv again", 1, nAdv);
		end
		// stop by command: burst still runs, advances withheld
		cmd(32'h203);
		cmd(32'h403);
		pulses(6);
		check("adv stop cmd", 0, nAdv);
		check("ctl stop cmd", 5, nCtl);
		conclude();
	end
endmodule
